// ===== common/ident_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ident_mem_if #(parameter int AW = 8, parameter int DW = 16);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic rd_en;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	modport ctl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

// ===== common/ident_pkg.sv
`default_nettype none
package ident_pkg;
	// =====================================================
	// Geometry of the parameter block
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned BLOCK_WORDS = 256;
	localparam int MODEL_CHARS = 40;
	localparam int SERIAL_CHARS = 20;
	// =====================================================
	// Word indices
	localparam logic [7:0] W_SERIAL = 8'h0a;
	localparam logic [7:0] W_SERIAL_LAST = 8'h13;
	localparam logic [7:0] W_MODEL = 8'h1b;
	localparam logic [7:0] W_MODEL_LAST = 8'h2e;
	localparam logic [7:0] W_MULT_MAX = 8'h2f;
	localparam logic [7:0] W_CAPS = 8'h31;
	localparam logic [7:0] W_PIO = 8'h33;
	localparam logic [7:0] W_VALID = 8'h35;
	localparam logic [7:0] W_CUR_CYL = 8'h36;
	localparam logic [7:0] W_CUR_HEAD = 8'h37;
	localparam logic [7:0] W_CUR_SEC = 8'h38;
	localparam logic [7:0] W_CAP_LO = 8'h39;
	localparam logic [7:0] W_CAP_HI = 8'h3a;
	localparam logic [7:0] W_MULT_SET = 8'h3b;
	localparam logic [7:0] W_LBA_LO = 8'h3c;
	localparam logic [7:0] W_LBA_HI = 8'h3d;
	localparam logic [7:0] W_MWDMA = 8'h3f;
	localparam logic [7:0] W_ADV_PIO = 8'h40;
	// =====================================================
	// Field values and bit positions
	localparam logic [7:0] SPACE_CHAR = 8'h20;
	localparam logic [7:0] MULT_MAX_TAG = 8'h80;
	localparam logic [1:0] PIO_MODE_TOP = 2'h2;
	localparam logic [1:0] MWDMA_MODE_TOP = 2'h2;
	localparam int CAP_STANDBY = 13;
	localparam int CAP_IORDY = 11;
	localparam int CAP_IORDY_DIS = 10;
	localparam int CAP_LBA = 9;
	localparam int CAP_DMA = 8;
	localparam int VALID_CHS = 0;
	localparam int VALID_EXT = 1;
	localparam int MULT_SET_VALID = 8;
	// =====================================================
	// Build sequencer
	typedef enum logic [1:0] {ST_IDLE, ST_SNAP, ST_CALC, ST_FILL} build_state_t;
endpackage
`default_nettype wire

// ===== rtl/ident_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ident_mem #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	input wire logic sys_clk_i,
	ident_mem_if.mem port_if
);
	// =====================================================
	// Word store, read data held in a register
	logic [DW-1:0] store_r [0:(1<<AW)-1];
	logic [DW-1:0] rd_data_r;

	always_ff @(posedge sys_clk_i)
	begin
		if (port_if.wr_en)
		begin
			store_r[port_if.wr_addr] <= port_if.wr_data;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (port_if.rd_en)
		begin
			rd_data_r <= store_r[port_if.rd_addr];
		end
	end

	assign port_if.rd_data = rd_data_r;
endmodule
`default_nettype wire

// ===== rtl/identify_words.sv
// Contract
// - Model text starts at first position, unused tail filled with spaces.
// - Multiple limit word upper byte is 80h.
// - Multiple limit low byte gives largest sectors per block accepted.
// - Capability bit 13 set when standby timer follows idle command.
// - Capability bit 11 set only when IORDY flow control is supported.
// - Capability bit 10 always zero: IORDY cannot be disabled.
// - Capability bit 9 always one: LBA addressing accepted.
// - Capability bit 8 zero: DMA read and write not supported.
// - PIO mode word upper byte only 00h, 01h or 02h.
// - Validity word bit 0 one: current geometry words valid.
// - Validity bit 1 one while words 64 to 70 hold valid values.
// - Current geometry words report live cylinders, heads, sectors per track.
// - Current capacity equals cylinders times heads times sectors.
// - Multiple setting word: bits 15-9 zero, bit 8 one, low byte live.
// - LBA sector total reported in its own double word.
// - DMA selected byte of word 63 one-hot, or zero while no mode is selected, bits 15-11 zero.
// - DMA supported byte of word 63 uses bits 2-0 only.
// - DMA modes 3 and above never appear in word 63.
// - Word 64 low byte maps supported advanced PIO modes.
// - Extended fields present, so word 53 bit 1 is set.
// - Serial text right aligned, unused leading positions are spaces.
`timescale 1ns/1ps
`default_nettype none
module identify_words
	import ident_pkg::*;
#(
	parameter logic [7:0] MULT_MAX_SECT = 8'h01
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic build_i,
	input wire logic rd_i,
	input wire logic [7:0] rd_addr_i,
	input wire logic [319:0] model_text_i,
	input wire logic [5:0] model_len_i,
	input wire logic [159:0] serial_text_i,
	input wire logic [4:0] serial_len_i,
	input wire logic standby_std_i,
	input wire logic iordy_sup_i,
	input wire logic [1:0] pio_mode_i,
	input wire logic [15:0] cur_cyl_i,
	input wire logic [15:0] cur_head_i,
	input wire logic [15:0] cur_sec_i,
	input wire logic [7:0] mult_cur_i,
	input wire logic [31:0] lba_total_i,
	input wire logic mwdma_sel_en_i,
	input wire logic [1:0] mwdma_sel_i,
	input wire logic [2:0] mwdma_sup_i,
	input wire logic [7:0] adv_pio_sup_i,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic busy_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// =====================================================
	// Word store
	ident_mem_if #(.AW(ADDR_W), .DW(WORD_W)) mem_if ();

	ident_mem #(.AW(ADDR_W), .DW(WORD_W)) u_mem (
		.sys_clk_i(sys_clk_i),
		.port_if(mem_if)
	);

	// =====================================================
	// Snapshot of the live settings
	build_state_t state_r;
	logic [7:0] fill_idx_r;
	logic [319:0] model_r;
	logic [5:0] model_len_r;
	logic [159:0] serial_r;
	logic [4:0] serial_len_r;
	logic standby_r;
	logic iordy_r;
	logic [1:0] pio_r;
	logic [15:0] cyl_r;
	logic [15:0] head_r;
	logic [15:0] sec_r;
	logic [31:0] cap_r;
	logic [47:0] cap_full;
	logic [7:0] mult_r;
	logic [31:0] lba_r;
	logic [2:0] dma_sel_r;
	logic [2:0] dma_sup_r;
	logic [7:0] adv_pio_r;

	always_ff @(posedge sys_clk_i)
	begin
		if (state_r == ST_SNAP)
		begin
			model_r <= model_text_i;
			model_len_r <= model_len_i;
			serial_r <= serial_text_i;
			serial_len_r <= serial_len_i;
			standby_r <= standby_std_i;
			iordy_r <= iordy_sup_i;
			// A mode above the top one would be illegal, so clamp it
			pio_r <= (pio_mode_i > PIO_MODE_TOP) ? PIO_MODE_TOP : pio_mode_i;
			cyl_r <= cur_cyl_i;
			head_r <= cur_head_i;
			sec_r <= cur_sec_i;
			mult_r <= mult_cur_i;
			lba_r <= lba_total_i;
			// Encoding from a mode number keeps the byte one-hot by design
			if (mwdma_sel_en_i)
			begin
				dma_sel_r <= (mwdma_sel_i > MWDMA_MODE_TOP) ? 3'h4 :
					3'(3'h1 << mwdma_sel_i);
			end
			else
			begin
				dma_sel_r <= 3'h0;
			end
			dma_sup_r <= mwdma_sup_i;
			adv_pio_r <= adv_pio_sup_i;
		end
	end

	// =====================================================
	// Capacity, one cycle after the snapshot
	assign cap_full = 48'(cyl_r) * 48'(head_r) * 48'(sec_r);

	always_ff @(posedge sys_clk_i)
	begin
		if (state_r == ST_CALC)
		begin
			cap_r <= cap_full[31:0];
		end
	end

	// =====================================================
	// Word assembly
	function automatic logic [7:0] model_char(input int k);
		int len;
		len = (int'(model_len_r) > MODEL_CHARS) ? MODEL_CHARS : int'(model_len_r);
		if (k < len)
		begin
			model_char = model_r[(MODEL_CHARS-1-k)*8 +: 8];
		end
		else
		begin
			model_char = SPACE_CHAR;
		end
	endfunction

	function automatic logic [7:0] serial_char(input int p);
		int len;
		int pad;
		len = (int'(serial_len_r) > SERIAL_CHARS) ? SERIAL_CHARS :
			int'(serial_len_r);
		pad = SERIAL_CHARS - len;
		if (p >= pad)
		begin
			serial_char = serial_r[(SERIAL_CHARS-1-(p-pad))*8 +: 8];
		end
		else
		begin
			serial_char = SPACE_CHAR;
		end
	endfunction

	function automatic logic [15:0] word_of(input logic [7:0] idx);
		int p;
		p = 0;
		word_of = 16'h0000;
		if (idx >= W_SERIAL && idx <= W_SERIAL_LAST)
		begin
			p = 2 * int'(idx - W_SERIAL);
			word_of = {serial_char(p), serial_char(p + 1)};
		end
		else if (idx >= W_MODEL && idx <= W_MODEL_LAST)
		begin
			p = 2 * int'(idx - W_MODEL);
			word_of = {model_char(p), model_char(p + 1)};
		end
		else
		begin
			unique case (idx)
				W_MULT_MAX: word_of = {MULT_MAX_TAG, MULT_MAX_SECT};
				W_CAPS:
				begin
					word_of[CAP_STANDBY] = standby_r;
					word_of[CAP_IORDY] = iordy_r;
					word_of[CAP_IORDY_DIS] = 1'b0;
					word_of[CAP_LBA] = 1'b1;
					word_of[CAP_DMA] = 1'b0;
				end
				W_PIO: word_of = {6'h00, pio_r, 8'h00};
				W_VALID:
				begin
					word_of[VALID_CHS] = 1'b1;
					word_of[VALID_EXT] = 1'b1;
				end
				W_CUR_CYL: word_of = cyl_r;
				W_CUR_HEAD: word_of = head_r;
				W_CUR_SEC: word_of = sec_r;
				W_CAP_LO: word_of = cap_r[15:0];
				W_CAP_HI: word_of = cap_r[31:16];
				W_MULT_SET:
				begin
					word_of[MULT_SET_VALID] = 1'b1;
					word_of[7:0] = mult_r;
				end
				W_LBA_LO: word_of = lba_r[15:0];
				W_LBA_HI: word_of = lba_r[31:16];
				// Only modes 0-2 fit here; a higher selection was encoded as mode 2 at the snapshot
				W_MWDMA:
					word_of = {5'h00, dma_sel_r, 5'h00, dma_sup_r};
				W_ADV_PIO: word_of = {8'h00, adv_pio_r};
				default: word_of = 16'h0000;
			endcase
		end
	endfunction

	// =====================================================
	// Build sequencer: reset and a build request while idle rebuild the block
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state_r <= ST_SNAP;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE: if (build_i) state_r <= ST_SNAP;
				ST_SNAP: state_r <= ST_CALC;
				ST_CALC: state_r <= ST_FILL;
				ST_FILL: if (fill_idx_r == 8'hff) state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || state_r != ST_FILL)
		begin
			fill_idx_r <= 8'h00;
		end
		else
		begin
			fill_idx_r <= fill_idx_r + 8'h01;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			busy_o <= 1'b1;
		end
		else
		begin
			busy_o <= !(state_r == ST_FILL && fill_idx_r == 8'hff) &&
				(state_r != ST_IDLE || build_i);
		end
	end

	assign mem_if.wr_en = (state_r == ST_FILL);
	assign mem_if.wr_addr = fill_idx_r;
	// A process, so a change of the snapshot re-evaluates the word too
	always_comb mem_if.wr_data = word_of(fill_idx_r);

	// =====================================================
	// Host read path
	// Reads while a rebuild is pending are dropped: half-built data
	// would mix old and new settings
	logic rd_take;
	logic rd_q1_r;
	logic [7:0] addr_q1_r;
	logic [7:0] addr_q2_r;

	assign rd_take = rd_i && !busy_o && !build_i;
	assign mem_if.rd_en = rd_take;
	assign mem_if.rd_addr = rd_addr_i;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			rd_q1_r <= 1'b0;
			rd_valid_o <= 1'b0;
		end
		else
		begin
			rd_q1_r <= rd_take;
			rd_valid_o <= rd_q1_r;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			rd_data_o <= 16'h0000;
		end
		else if (rd_q1_r)
		begin
			rd_data_o <= mem_if.rd_data;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		addr_q1_r <= rd_addr_i;
		addr_q2_r <= addr_q1_r;
	end

	// =====================================================
	// Checks on returned words
	logic [47:0] cap_chk;
	assign cap_chk = 48'(cyl_r) * 48'(head_r) * 48'(sec_r);

	AST_MODEL_TAIL: assert property (
		rd_valid_o && addr_q2_r == W_MODEL_LAST && model_len_r < 6'h27
		|-> rd_data_o == {SPACE_CHAR, SPACE_CHAR})
		else $error("model tail not padded");
	AST_SERIAL_HEAD: assert property (
		rd_valid_o && addr_q2_r == W_SERIAL && serial_len_r < 5'h13
		|-> rd_data_o == {SPACE_CHAR, SPACE_CHAR})
		else $error("serial head not padded");
	AST_MULT_MAX: assert property (
		rd_valid_o && addr_q2_r == W_MULT_MAX
		|-> rd_data_o == {MULT_MAX_TAG, MULT_MAX_SECT})
		else $error("multiple limit word wrong");
	AST_CAPS: assert property (
		rd_valid_o && addr_q2_r == W_CAPS
		|-> rd_data_o[10:8] == 3'h2 && rd_data_o[13] == standby_r &&
		rd_data_o[11] == iordy_r)
		else $error("capability word wrong");
	AST_PIO: assert property (
		rd_valid_o && addr_q2_r == W_PIO
		|-> rd_data_o[15:8] <= 8'h02 && rd_data_o[7:0] == 8'h00)
		else $error("pio mode out of range");
	AST_VALID: assert property (
		rd_valid_o && addr_q2_r == W_VALID |-> rd_data_o == 16'h0003)
		else $error("validity word wrong");
	AST_CAPACITY: assert property (
		rd_valid_o && addr_q2_r == W_CAP_LO |-> rd_data_o == cap_chk[15:0])
		else $error("capacity low word wrong");
	AST_MULT_SET: assert property (
		rd_valid_o && addr_q2_r == W_MULT_SET
		|-> rd_data_o[15:8] == 8'h01 && rd_data_o[7:0] == mult_r)
		else $error("multiple setting word wrong");
	AST_MWDMA: assert property (
		rd_valid_o && addr_q2_r == W_MWDMA
		|-> $onehot0(rd_data_o[15:8]) && rd_data_o[15:11] == 5'h00 &&
		rd_data_o[7:3] == 5'h00)
		else $error("dma word malformed");
	AST_REFUSE: assert property (
		busy_o && !$past(rd_take) |=> !rd_q1_r ##1 !rd_valid_o)
		else $error("read served during rebuild");
endmodule
`default_nettype wire

// ===== sim/ident_host.sv
`timescale 1ns/1ps
`default_nettype none
module ident_host (
	input wire logic sys_clk_i,
	output logic rd_o,
	output logic [7:0] rd_addr_o,
	input wire logic [15:0] rd_data_i,
	input wire logic rd_valid_i
);
	// =====================================================
	// Host side reader: one word per request
	initial
	begin
		rd_o = 1'b0;
		rd_addr_o = 8'h00;
	end

	// Only the answer one edge after the taking edge counts; a stray
	// valid in either of the two cycles after it clears got so the bench sees it
	task automatic read_word(input logic [7:0] a, output logic got,
		output logic [15:0] d);
		logic bad;
		bad = 1'b0;
		got = 1'b0;
		d = 16'h0000;
		@(posedge sys_clk_i);
		rd_o <= 1'b1;
		rd_addr_o <= a;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		// Address no longer qualified: drive the inverted address
		rd_addr_o <= ~a;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge sys_clk_i);
			#1;
			if (i == 0)
			begin
				got = (rd_valid_i === 1'b1);
				d = rd_data_i;
			end
			else if (rd_valid_i !== 1'b0)
				bad = 1'b1;
		end
		if (bad)
			got = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ident_pkg::*;
	localparam logic [7:0] MULT_MAX = 8'h10;
	logic clk, rst, build, rd, rd_valid, busy, sb, io, sel_en;
	logic [7:0] rd_addr, mult, adv;
	logic [319:0] model_text;
	logic [5:0] model_len;
	logic [159:0] serial_text;
	logic [4:0] serial_len;
	logic [1:0] pio, sel;
	logic [2:0] sup;
	logic [15:0] cyl, head, sec, rd_data;
	logic [31:0] lba, cap;
	int n_mismatch = 0;
	int n_checks = 0;

	identify_words #(.MULT_MAX_SECT(MULT_MAX)) u_identify_words (
		.sys_clk_i(clk), .rst_i(rst), .build_i(build), .rd_i(rd),
		.rd_addr_i(rd_addr), .model_text_i(model_text),
		.model_len_i(model_len), .serial_text_i(serial_text),
		.serial_len_i(serial_len), .standby_std_i(sb), .iordy_sup_i(io),
		.pio_mode_i(pio), .cur_cyl_i(cyl), .cur_head_i(head),
		.cur_sec_i(sec), .mult_cur_i(mult), .lba_total_i(lba),
		.mwdma_sel_en_i(sel_en), .mwdma_sel_i(sel), .mwdma_sup_i(sup),
		.adv_pio_sup_i(adv), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.busy_o(busy));

	ident_host u_ident_host (.sys_clk_i(clk), .rd_o(rd),
		.rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

	// =====================================================
	// Checking helpers
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic word(input logic [7:0] a, input logic [15:0] exp);
		logic got;
		logic [15:0] d;
		u_ident_host.read_word(a, got, d);
		check($sformatf("served word %0d", a), {15'h0000, got}, 16'h0001);
		check($sformatf("word %0d", a), d, exp);
	endtask

	task automatic conclude;
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// A read issued mid-rebuild must be dropped, not stalled
	task automatic rebuild(input logic probe);
		logic got;
		logic [15:0] d;
		int i;
		@(posedge clk);
		build <= 1'b1;
		@(posedge clk);
		build <= 1'b0;
		@(posedge clk);
		#1;
		check("busy after build", {15'h0000, busy}, 16'h0001);
		if (probe)
		begin
			u_ident_host.read_word(W_CAPS, got, d);
			check("read in rebuild", {15'h0000, got}, 16'h0000);
		end
		for (i = 0; i < 400 && busy !== 1'b0; i++)
			@(posedge clk);
		check("busy end", {15'h0000, busy}, 16'h0000);
	endtask

	// =====================================================
	// Scenarios
	// Text padding: model left aligned, serial right aligned
	task automatic test_text;
		word(8'h1b, 16'h4142);
		word(8'h1d, 16'h4520);
		word(8'h2e, 16'h2020);
		word(8'h0a, 16'h2020);
		word(8'h12, 16'h2058);
		word(8'h13, 16'h595a);
		// Lengths past the field clamp to the full field, no padding
		model_len <= 6'h3f;
		serial_len <= 5'h1f;
		rebuild(1'b0);
		word(8'h2e, 16'h6768);
		word(8'h0a, 16'h5859);
		word(8'h13, 16'h3f3f);
	endtask

	// Every mode code in turn, settings changed before each rebuild
	task automatic test_modes;
		logic [1:0] pm;
		for (int m = 0; m < 4; m++)
		begin
			sb <= m[0];
			io <= m[1];
			pio <= 2'(m);
			sel <= 2'(m);
			sel_en <= (m != 1);
			sup <= 3'(1 << (m % 3));
			adv <= 8'(1 << m);
			mult <= 8'(4 * m + 1);
			cyl <= 16'h0123 + 16'(m);
			head <= 16'h0004;
			sec <= 16'h0011;
			lba <= 32'h0001_0000 * m + 32'h1234;
			rebuild(m == 2);
			pm = (m == 3) ? 2'h2 : 2'(m);
			cap = 32'(cyl) * 32'(head) * 32'(sec);
			word(W_MULT_MAX, {8'h80, MULT_MAX});
			word(W_CAPS, {2'h0, sb, 1'b0, io, 3'h2, 8'h00});
			word(W_PIO, {6'h00, pm, 8'h00});
			word(W_VALID, 16'h0003);
			word(W_CUR_CYL, cyl);
			word(W_CUR_HEAD, head);
			word(W_CUR_SEC, sec);
			word(W_CAP_LO, cap[15:0]);
			word(W_CAP_HI, cap[31:16]);
			word(W_MULT_SET, {8'h01, mult});
			word(W_LBA_LO, lba[15:0]);
			word(W_LBA_HI, lba[31:16]);
			word(W_MWDMA, {sel_en ? 8'(1 << pm) : 8'h00, 5'h00, sup});
			word(W_ADV_PIO, {8'h00, adv});
			word(8'h32, 16'h0000);
			word(8'h3e, 16'h0000);
		end
	endtask

	// =====================================================
	// Clock, stimulus and watchdog
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		rst = 1'b1;
		build = 1'b0;
		sb = 1'b1;
		io = 1'b1;
		sel_en = 1'b0;
		mult = 8'h00;
		adv = 8'h00;
		pio = 2'h0;
		sel = 2'h0;
		sup = 3'h0;
		cyl = 16'h0001;
		head = 16'h0001;
		sec = 16'h0001;
		lba = 32'h0;
		for (int k = 0; k < 40; k++)
			model_text[(39 - k) * 8 +: 8] = 8'h41 + 8'(k);
		model_len = 6'h05;
		// Junk past the used length shows whether padding replaces it
		serial_text = {8'h58, 8'h59, 8'h5a, {17{8'h3f}}};
		serial_len = 5'h03;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 400 && busy !== 1'b0; i++)
			@(posedge clk);
		test_text();
		test_modes();
		conclude();
	end

	// The reset build, five rebuilds and the reads take well under ten thousand cycles
	initial
	begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
